// ### shared/blnvm_params.svh
// Constants for the backlight register file and nonvolatile transfer control
// Overview of operation
// - Each override bit forces one sink full duty
// - Eleven-bit temperature split over two read registers
// - Upper read latches reading; host reads upper first
// - Control bit 7 reads 0 busy, 1 idle
// - Reload bit copies nonvolatile image into shadows
// - Shadow writes take effect immediately, uncommitted volatile
// - Power-up loads nonvolatile image into shadows automatically
`ifndef BLNVM_PARAMS_SVH
`define BLNVM_PARAMS_SVH
`define BLNVM_ADDR_OVERRIDE 8'h04
`define BLNVM_ADDR_HEAT_UP 8'h05
`define BLNVM_ADDR_HEAT_LO 8'h06
`define BLNVM_ADDR_CTRL 8'h72
`define BLNVM_ADDR_SHADOW_BASE 8'hA0
`define BLNVM_ADDR_SHADOW_LAST 8'hA7
`define BLNVM_RST_OVERRIDE 6'h00
`define BLNVM_RST_HEAT 11'h000
`define BLNVM_RST_CTRL 3'h0
`define BLNVM_BIT_IDLE 7
`define BLNVM_BIT_ARM 2
`define BLNVM_BIT_BURN 1
`define BLNVM_BIT_RELOAD 0
`define BLNVM_HEAT_LO_POS 5
`endif

// ### shared/blnvm_pkg.sv
// Types shared by the backlight nonvolatile transfer block
package blnvm_pkg;
   typedef enum logic [2:0] {
      BLNVM_ST_BOOT = 3'b001,
      BLNVM_ST_IDLE = 3'b010,
      BLNVM_ST_BUSY = 3'b100
   } blnvm_state_type;

   // One-cycle command to the nonvolatile macro
   typedef struct packed {
      logic burn;
      logic load;
      logic [7:0][7:0] image;
   } blnvm_cmd_type;

   // Register port request from the serial engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } blnvm_req_type;
endpackage : blnvm_pkg

// ### core/blnvm_core.sv
// Override, temperature readout and nonvolatile transfer control registers
`timescale 1ns/10ps
`include "blnvm_params.svh"
module blnvm_core #(
   parameter int LEDS = 6,
   parameter int HEAT_W = 11
) (
   input wire logic clock,
   input wire logic resetn,
   input wire blnvm_pkg::blnvm_req_type req,
   input wire logic [HEAT_W-1:0] heat_in,
   input wire logic nvm_done,
   input wire logic [7:0][7:0] nvm_image,
   output logic [7:0] rdata_q,
   output logic [LEDS-1:0] led_force_q,
   output logic [7:0][7:0] shadow_q,
   output blnvm_pkg::blnvm_cmd_type nvm_cmd_q
);
   blnvm_pkg::blnvm_state_type state_q;
   logic [HEAT_W-1:0] heat_latch_q;
   logic [2:0] ctrl_q;
   logic op_load_q;
   logic ctrl_wr;
   logic start;
   logic shadow_hit;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      hit = (a == ref_a);
   endfunction : hit

   assign ctrl_wr = req.wr && hit(req.addr, `BLNVM_ADDR_CTRL);
   // Only an armed, idle controller starts; writes while busy never restart
   assign start = ctrl_wr && (state_q == blnvm_pkg::BLNVM_ST_IDLE)
      && ctrl_q[`BLNVM_BIT_ARM]
      && (req.wdata[`BLNVM_BIT_BURN] || req.wdata[`BLNVM_BIT_RELOAD]);
   assign shadow_hit = (req.addr >= `BLNVM_ADDR_SHADOW_BASE)
      && (req.addr <= `BLNVM_ADDR_SHADOW_LAST);

   // Sink override
   always_ff @(posedge clock) begin
      if (!resetn) begin
         led_force_q <= LEDS'(`BLNVM_RST_OVERRIDE);
      end else if (req.wr && hit(req.addr, `BLNVM_ADDR_OVERRIDE)) begin
         led_force_q <= req.wdata[LEDS-1:0];
      end
   end

   override_hold_a: assert property (@(posedge clock) disable iff (!resetn)
      !(req.wr && hit(req.addr, `BLNVM_ADDR_OVERRIDE)) |=> $stable(led_force_q))
      else $error("override moved without write");

   // Upper read captures the whole reading so the lower half stays coherent
   always_ff @(posedge clock) begin
      if (!resetn) begin
         heat_latch_q <= HEAT_W'(`BLNVM_RST_HEAT);
      end else if (req.rd && hit(req.addr, `BLNVM_ADDR_HEAT_UP)) begin
         heat_latch_q <= heat_in;
      end
   end

   heat_latch_a: assert property (@(posedge clock) disable iff (!resetn)
      req.rd && hit(req.addr, `BLNVM_ADDR_HEAT_UP) |=> heat_latch_q == $past(heat_in))
      else $error("reading not latched");

   // Control bits as last written
   always_ff @(posedge clock) begin
      if (!resetn) begin
         ctrl_q <= `BLNVM_RST_CTRL;
      end else if (ctrl_wr) begin
         ctrl_q <= req.wdata[2:0];
      end
   end

   ctrl_store_a: assert property (@(posedge clock) disable iff (!resetn)
      ctrl_wr |=> ctrl_q == $past(req.wdata[2:0]))
      else $error("control bits not stored");

   // Transfer sequencer
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_q <= blnvm_pkg::BLNVM_ST_BOOT;
         op_load_q <= 1'b0;
         nvm_cmd_q <= '0;
      end else begin
         nvm_cmd_q.burn <= 1'b0;
         nvm_cmd_q.load <= 1'b0;
         unique case (state_q)
            blnvm_pkg::BLNVM_ST_BOOT: begin
               nvm_cmd_q.load <= 1'b1;
               op_load_q <= 1'b1;
               state_q <= blnvm_pkg::BLNVM_ST_BUSY;
            end
            blnvm_pkg::BLNVM_ST_IDLE: begin
               if (start) begin
                  // Burn takes priority if both trigger bits are written
                  nvm_cmd_q.burn <= req.wdata[`BLNVM_BIT_BURN];
                  nvm_cmd_q.load <= !req.wdata[`BLNVM_BIT_BURN];
                  nvm_cmd_q.image <= shadow_q;
                  op_load_q <= !req.wdata[`BLNVM_BIT_BURN];
                  state_q <= blnvm_pkg::BLNVM_ST_BUSY;
               end
            end
            blnvm_pkg::BLNVM_ST_BUSY: begin
               if (nvm_done) begin
                  state_q <= blnvm_pkg::BLNVM_ST_IDLE;
               end
            end
         endcase
      end
   end

   // Done is trusted only while busy; a stray pulse when idle is ignored
   unarmed_start_a: assert property (@(posedge clock) disable iff (!resetn)
      ctrl_wr && !ctrl_q[`BLNVM_BIT_ARM] |=> !nvm_cmd_q.burn && !nvm_cmd_q.load)
      else $error("transfer started unarmed");
   burn_start_a: assert property (@(posedge clock) disable iff (!resetn)
      start && req.wdata[`BLNVM_BIT_BURN] |=> nvm_cmd_q.burn && !nvm_cmd_q.load
      && nvm_cmd_q.image == $past(shadow_q) && state_q == blnvm_pkg::BLNVM_ST_BUSY)
      else $error("program not started");
   cmd_pulse_a: assert property (@(posedge clock) disable iff (!resetn)
      nvm_cmd_q.burn || nvm_cmd_q.load |=> !nvm_cmd_q.burn && !nvm_cmd_q.load)
      else $error("command longer than one cycle");
   idle_quiet_a: assert property (@(posedge clock) disable iff (!resetn)
      state_q == blnvm_pkg::BLNVM_ST_IDLE && !start |=> !nvm_cmd_q.burn && !nvm_cmd_q.load
      && state_q == blnvm_pkg::BLNVM_ST_IDLE)
      else $error("transfer without trigger");
   image_hold_a: assert property (@(posedge clock) disable iff (!resetn)
      !start |=> $stable(nvm_cmd_q.image))
      else $error("snapshot moved mid transfer");
   boot_busy_a: assert property (@(posedge clock) disable iff (!resetn)
      state_q == blnvm_pkg::BLNVM_ST_BOOT
      |=> state_q == blnvm_pkg::BLNVM_ST_BUSY && op_load_q)
      else $error("power-up load not pending");

   // Shadow configuration; outputs follow writes at once, a finished load wins
   always_ff @(posedge clock) begin
      if (!resetn) begin
         shadow_q <= '0;
      end else if (state_q == blnvm_pkg::BLNVM_ST_BUSY && nvm_done && op_load_q) begin
         shadow_q <= nvm_image;
      end else if (req.wr && shadow_hit) begin
         shadow_q[req.addr[2:0]] <= req.wdata;
      end
   end

   // A host write that meets a finished load is lost, so it is not checked
   shadow_write_a: assert property (@(posedge clock) disable iff (!resetn)
      req.wr && shadow_hit && !(state_q == blnvm_pkg::BLNVM_ST_BUSY && nvm_done && op_load_q)
      |=> shadow_q[$past(req.addr[2:0])] == $past(req.wdata))
      else $error("shadow write not effective");
   shadow_hold_a: assert property (@(posedge clock) disable iff (!resetn)
      !(req.wr && shadow_hit) && !(state_q == blnvm_pkg::BLNVM_ST_BUSY && nvm_done)
      |=> $stable(shadow_q))
      else $error("shadow moved without write or load");

   // Read data, registered one cycle after the read strobe
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
      end else if (req.rd) begin
         if (hit(req.addr, `BLNVM_ADDR_OVERRIDE)) begin
            rdata_q <= 8'(led_force_q);
         end else if (hit(req.addr, `BLNVM_ADDR_HEAT_UP)) begin
            rdata_q <= heat_in[HEAT_W-1:3];
         end else if (hit(req.addr, `BLNVM_ADDR_HEAT_LO)) begin
            rdata_q <= {heat_latch_q[2:0], 5'b0_0000};
         end else if (hit(req.addr, `BLNVM_ADDR_CTRL)) begin
            rdata_q <= {state_q == blnvm_pkg::BLNVM_ST_IDLE, 4'h0, ctrl_q};
         end else if (shadow_hit) begin
            rdata_q <= shadow_q[req.addr[2:0]];
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   rdata_hold_a: assert property (@(posedge clock) disable iff (!resetn)
      !req.rd |=> $stable(rdata_q))
      else $error("read data moved without read");
   heat_lower_a: assert property (@(posedge clock) disable iff (!resetn)
      req.rd && hit(req.addr, `BLNVM_ADDR_HEAT_LO) |=> rdata_q[4:0] == 5'h00)
      else $error("lower temperature padding set");
   ctrl_read_a: assert property (@(posedge clock) disable iff (!resetn)
      req.rd && hit(req.addr, `BLNVM_ADDR_CTRL) && state_q == blnvm_pkg::BLNVM_ST_IDLE
      |=> rdata_q[7] && rdata_q[6:3] == 4'h0)
      else $error("idle not shown");
   override_read_a: assert property (@(posedge clock) disable iff (!resetn)
      req.rd && hit(req.addr, `BLNVM_ADDR_OVERRIDE) |=> rdata_q == 8'($past(led_force_q)))
      else $error("override read wrong");
   reset_clear_a: assert property (@(posedge clock)
      !resetn |=> rdata_q == 8'h00 && led_force_q == '0 && shadow_q == '0 && nvm_cmd_q == '0)
      else $error("outputs not cleared in reset");

   override_write_a: assert property (@(posedge clock) disable iff (!resetn)
      req.wr && hit(req.addr, `BLNVM_ADDR_OVERRIDE) |=> led_force_q == $past(req.wdata[5:0]))
      else $error("override not stored");
   heat_upper_a: assert property (@(posedge clock) disable iff (!resetn)
      req.rd && hit(req.addr, `BLNVM_ADDR_HEAT_UP) |=> rdata_q == $past(heat_in[10:3]))
      else $error("upper temperature wrong");
   heat_coherent_a: assert property (@(posedge clock) disable iff (!resetn)
      req.rd && hit(req.addr, `BLNVM_ADDR_HEAT_UP) ##1
      (req.rd && hit(req.addr, `BLNVM_ADDR_HEAT_LO))
      |=> rdata_q == {$past(heat_in[2:0], 2), 5'b0_0000})
      else $error("lower temperature incoherent");
   latch_stable_a: assert property (@(posedge clock) disable iff (!resetn)
      !(req.rd && hit(req.addr, `BLNVM_ADDR_HEAT_UP)) |=> $stable(heat_latch_q))
      else $error("latch moved without upper read");
   busy_flag_a: assert property (@(posedge clock) disable iff (!resetn)
      req.rd && hit(req.addr, `BLNVM_ADDR_CTRL) && state_q != blnvm_pkg::BLNVM_ST_IDLE
      |=> !rdata_q[7])
      else $error("ready shown while busy");
   armed_start_a: assert property (@(posedge clock) disable iff (!resetn)
      start && !req.wdata[1] |=> nvm_cmd_q.load && state_q == blnvm_pkg::BLNVM_ST_BUSY)
      else $error("reload not started");
   no_restart_a: assert property (@(posedge clock) disable iff (!resetn)
      state_q == blnvm_pkg::BLNVM_ST_BUSY && !nvm_done |=> !nvm_cmd_q.burn && !nvm_cmd_q.load
      && state_q == blnvm_pkg::BLNVM_ST_BUSY)
      else $error("transfer restarted or dropped");
   boot_load_a: assert property (@(posedge clock)
      $rose(resetn) |=> nvm_cmd_q.load ##1 state_q == blnvm_pkg::BLNVM_ST_BUSY)
      else $error("no power-up load");
   load_copy_a: assert property (@(posedge clock) disable iff (!resetn)
      state_q == blnvm_pkg::BLNVM_ST_BUSY && nvm_done && op_load_q
      |=> shadow_q == $past(nvm_image) && state_q == blnvm_pkg::BLNVM_ST_IDLE)
      else $error("image not copied");
endmodule : blnvm_core

// ### sim/blnvm_nvm_model.sv
// Behavioural nonvolatile macro answering load and burn commands
`timescale 1ns/10ps
module blnvm_nvm_model #(
   parameter int DELAY = 12,
   parameter logic [63:0] INIT = 64'h0123_4567_89ab_cdef
) (
   input wire logic clock,
   input wire logic resetn,
   input wire blnvm_pkg::blnvm_cmd_type cmd,
   output logic done,
   output logic [7:0][7:0] image
);
   logic [63:0] mem_q;
   int cnt_q;
   // Image only valid with done; inverted otherwise so stale use shows
   assign image = done ? mem_q : ~mem_q;
   assign done = (cnt_q == 1);
   always_ff @(posedge clock) begin
      if (!resetn) cnt_q <= 0;
      else if (cmd.burn || cmd.load) cnt_q <= DELAY;
      else if (cnt_q > 0) cnt_q <= cnt_q - 1;
   end
   always_ff @(posedge clock) begin
      if (!resetn) mem_q <= INIT;
      else if (cmd.burn) mem_q <= cmd.image;
   end
endmodule : blnvm_nvm_model

// ### sim/testbench.sv
// Random bench for override, temperature and nonvolatile control
`timescale 1ns/10ps
module testbench;
   localparam logic [63:0] INIT = 64'h0123_4567_89ab_cdef;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   blnvm_pkg::blnvm_req_type req = '0;
   logic [10:0] heat_in = 11'h000;
   logic nvm_done;
   logic [7:0][7:0] nvm_image;
   logic [7:0][7:0] shadow_q;
   logic [7:0] rdata_q;
   logic [5:0] led_force_q;
   blnvm_pkg::blnvm_cmd_type nvm_cmd_q;
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [63:0] img;
   logic [10:0] h;
   logic [5:0] f;
   logic [7:0] up_b;
   logic [7:0] lo_b;
   blnvm_core u_blnvm_core (.clock(clock), .resetn(resetn), .req(req), .heat_in(heat_in),
      .nvm_done(nvm_done), .nvm_image(nvm_image), .rdata_q(rdata_q),
      .led_force_q(led_force_q), .shadow_q(shadow_q), .nvm_cmd_q(nvm_cmd_q));
   blnvm_nvm_model #(.INIT(INIT)) u_blnvm_nvm_model (.clock(clock), .resetn(resetn),
      .cmd(nvm_cmd_q), .done(nvm_done), .image(nvm_image));
   initial begin
      forever #25 clock = ~clock;
   end
   function automatic logic [7:0] lo_exp(input logic [10:0] v);
      return {v[2:0], 5'b00000};
   endfunction : lo_exp
   function automatic logic [7:0] hi_exp(input logic [10:0] v);
      return v[10:3];
   endfunction : hi_exp
   task automatic end_of_test;
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [65:0] got, input logic [65:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One access: strobe for one cycle, then let the answer settle
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clock);
      req <= '0;
      #1;
   endtask : acc
   // Back-to-back upper then lower read; the reading changes between them
   task automatic heat_pair(output logic [7:0] up, output logic [7:0] lo);
      @(posedge clock);
      req <= '{wr: 1'b0, rd: 1'b1, addr: 8'h05, wdata: 8'h00};
      @(posedge clock);
      req <= '{wr: 1'b0, rd: 1'b1, addr: 8'h06, wdata: 8'h00};
      heat_in <= ~heat_in;
      #1;
      up = rdata_q;
      @(posedge clock);
      req <= '0;
      #1;
      lo = rdata_q;
   endtask : heat_pair
   task automatic wait_idle;
      for (int i = 0; i < 40; i++) begin
         acc(1'b0, 8'h72, 8'h00);
         if (rdata_q[7] === 1'b1) break;
      end
      chk(rdata_q[7], 1'b1);
   endtask : wait_idle
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         end_of_test();
      end
   end
   initial begin
      void'($urandom(32'ha227));
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      acc(1'b0, 8'h72, 8'h00);
      chk(rdata_q, 8'h00);
      wait_idle;
      chk(shadow_q, INIT);
      acc(1'b0, 8'h30, 8'h00);
      chk(rdata_q, 8'h00);
      for (int i = 0; i < 8; i++) begin
         f = 6'($urandom);
         h = 11'($urandom);
         acc(1'b1, 8'h04, {2'b00, f});
         chk(led_force_q, f);
         acc(1'b0, 8'h04, 8'h00);
         chk(rdata_q, {2'b00, f});
         @(posedge clock) heat_in <= h;
         acc(1'b0, 8'h05, 8'h00);
         chk(rdata_q, h[10:3]);
         @(posedge clock) heat_in <= ~h;
         acc(1'b0, 8'h06, 8'h00);
         chk(rdata_q, lo_exp(h));
         heat_pair(up_b, lo_b);
         chk(up_b, hi_exp(~h));
         chk(lo_b, lo_exp(~h));
         img[8*i +: 8] = 8'($urandom);
         acc(1'b1, 8'ha0 + 8'(i), img[8*i +: 8]);
         chk(shadow_q[i], img[8*i +: 8]);
      end
      // Transfers below are bench validation only, never a production flow
      acc(1'b1, 8'h01, 8'h05);
      acc(1'b1, 8'h72, 8'h04);
      acc(1'b1, 8'h72, 8'h02);
      chk(nvm_cmd_q, {2'b10, img});
      // Retrigger while busy must not start a second burn
      acc(1'b1, 8'h72, 8'h04);
      acc(1'b1, 8'h72, 8'h02);
      chk(nvm_cmd_q.burn, 1'b0);
      acc(1'b0, 8'h72, 8'h00);
      chk(rdata_q, 8'h02);
      wait_idle;
      acc(1'b1, 8'h72, 8'h00);
      acc(1'b1, 8'ha3, ~img[31:24]);
      acc(1'b1, 8'h72, 8'h04);
      acc(1'b1, 8'h72, 8'h01);
      chk(nvm_cmd_q.load, 1'b1);
      wait_idle;
      chk(shadow_q, img);
      acc(1'b1, 8'h72, 8'h00);
      // Both trigger bits together give a program only
      acc(1'b1, 8'h72, 8'h04);
      acc(1'b1, 8'h72, 8'h03);
      chk(nvm_cmd_q, {2'b10, img});
      wait_idle;
      acc(1'b1, 8'h72, 8'h00);
      acc(1'b1, 8'h72, 8'h01);
      chk(nvm_cmd_q.load, 1'b0);
      acc(1'b1, 8'h72, 8'h00);
      end_of_test();
   end
endmodule : testbench
